// [hdl/dir_id_store.sv]
// Purpose: programmable identification store, one-way bit programming
// Assumes: programming strobe is a single-cycle pulse on i_clk
// Notes:   programming only clears bits, like one-time cells
`timescale 1ns/1ps
module dir_id_store (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_ce,
  input  wire logic                      i_prog_stb,
  input  wire logic                      i_prog_sel,
  input  wire logic [dir_pkg::BYTE_W-1:0] i_prog_data,
  output dir_pkg::dir_id_word_t           o_word
);
  logic [dir_pkg::WORD_W-1:0] word_q;

  // a zero in the programmed data burns the bit; ones leave it alone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      word_q <= dir_pkg::ID_RESET;
    end else if (i_ce && i_prog_stb) begin
      if (i_prog_sel) begin
        word_q[15:8] <= word_q[15:8] & i_prog_data;
      end else begin
        word_q[7:0] <= word_q[7:0] & i_prog_data;
      end
    end
  end

  assign o_word = dir_pkg::dir_id_word_t'(word_q);

  bits_only_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (word_q & ~$past(word_q)) == 16'h0000)
    else $error("identification bit went from zero to one");

  prog_applies_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_prog_stb && !i_prog_sel) |=>
      word_q[7:0] == ($past(word_q[7:0]) & $past(i_prog_data)))
    else $error("first byte programming not applied");
endmodule // dir_id_store

// [hdl/dir_pkg.sv]
// Purpose: shared constants and types for the identification readout block
// Assumes: 22-bit program address space, 8-bit identification bytes
// Notes:   identification word is {second byte, first byte}
package dir_pkg;
  localparam int unsigned ADDR_W  = 22;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned CMD_W   = 4;
  localparam int unsigned CNT_W   = 3;

  localparam logic [ADDR_W-1:0] ID0_ADDR = 22'h3ffffe;
  localparam logic [ADDR_W-1:0] ID1_ADDR = 22'h3fffff;

  // field positions inside the first and second bytes
  localparam int unsigned REV_LSB  = 0;
  localparam int unsigned REV_W    = 5;
  localparam int unsigned PLO_LSB  = 5;
  localparam int unsigned PLO_W    = 3;
  localparam int unsigned PHI_LSB  = 0;
  localparam int unsigned PHI_W    = 8;

  // unprogrammed bits read as one
  localparam logic [WORD_W-1:0] ID_RESET = 16'hffff;

  // link commands: bit3 valid, bit2 program, bit0 byte select
  localparam logic [CMD_W-1:0] CMD_RD0 = 4'h8;
  localparam logic [CMD_W-1:0] CMD_RD1 = 4'h9;
  localparam logic [CMD_W-1:0] CMD_PG0 = 4'hc;
  localparam logic [CMD_W-1:0] CMD_PG1 = 4'hd;
  localparam logic [CNT_W-1:0] CMD_LAST  = 3'h3;
  localparam logic [CNT_W-1:0] DATA_LAST = 3'h7;

  typedef enum logic [1:0] {
    DIR_LNK_CMD = 2'b00,
    DIR_LNK_RD  = 2'b01,
    DIR_LNK_WR  = 2'b10
  } dir_lnk_state_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } dir_tbl_req_t;

  typedef struct packed {
    logic [PHI_W-1:0] part_code_high_bits;
    logic [PLO_W-1:0] part_code_low_bits;
    logic [REV_W-1:0] silicon_revision_field;
  } dir_id_word_t;
endpackage

// [hdl/dir_top.sv]
// Purpose: identification readout over table read and serial link
// Assumes: link clock comes from the programmer and stops between frames
// Notes:   i_lnk_vpp low holds the link logic idle; i_ce gates i_clk side
`timescale 1ns/1ps
module dir_top (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_ce,
  input  dir_pkg::dir_tbl_req_t            i_tbl_req,
  output logic [dir_pkg::BYTE_W-1:0]       o_tbl_data,
  output logic                             o_tbl_valid,
  output logic                             o_tbl_hit,
  input  wire logic                        i_lnk_clk,
  input  wire logic                        i_lnk_vpp,
  input  wire logic                        i_lnk_dat_i,
  output logic                             o_lnk_dat_o,
  output logic                             o_lnk_dat_oe
);
  // both paths go through this one decoder so they cannot disagree
  function automatic logic [dir_pkg::BYTE_W-1:0] id_byte(
    input dir_pkg::dir_id_word_t w,
    input logic                  sel
  );
    logic [dir_pkg::BYTE_W-1:0] b;
    b = '0;
    if (sel) begin
      b = w.part_code_high_bits;
    end else begin
      b = {w.part_code_low_bits, w.silicon_revision_field};
    end
    return b;
  endfunction

  dir_pkg::dir_id_word_t       id_word;
  logic                        prog_stb;
  logic                        lnk_rst_n;
  logic                        tgl_s1_q;
  logic                        tgl_s2_q;
  logic                        tgl_s3_q;
  logic                        tbl_hit;
  logic [dir_pkg::BYTE_W-1:0]  wr_data_q;
  logic                        wr_sel_q;
  logic                        wr_tgl_q;
  logic [dir_pkg::WORD_W-1:0]  id_s1_q;
  logic [dir_pkg::WORD_W-1:0]  id_s2_q;
  dir_pkg::dir_lnk_state_t     state_q;
  logic [dir_pkg::CNT_W-1:0]   cnt_q;
  logic [2:0]                  cmd_q;
  logic [dir_pkg::BYTE_W-1:0]  sh_q;
  logic [dir_pkg::CMD_W-1:0]   cmd_full;

  dir_id_store u_store (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_ce        (i_ce),
    .i_prog_stb  (prog_stb),
    .i_prog_sel  (wr_sel_q),
    .i_prog_data (wr_data_q),
    .o_word      (id_word)
  );

  // ---------------- firmware table-read side ----------------
  assign tbl_hit = (i_tbl_req.addr == dir_pkg::ID0_ADDR) ||
                   (i_tbl_req.addr == dir_pkg::ID1_ADDR);

  // writes are not decoded at all, so the store cannot be touched here
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tbl_data  <= '0;
      o_tbl_valid <= 1'b0;
      o_tbl_hit   <= 1'b0;
    end else if (i_ce) begin
      o_tbl_valid <= i_tbl_req.rd;
      if (i_tbl_req.rd) begin
        o_tbl_hit  <= tbl_hit;
        o_tbl_data <= tbl_hit ? id_byte(id_word, i_tbl_req.addr[0])
                              : '0;
      end
    end
  end

  // link program request: toggle crosses, data is held stable meanwhile
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else if (i_ce) begin
      tgl_s1_q <= wr_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign prog_stb = tgl_s2_q ^ tgl_s3_q;

  // ---------------- link side, programmer clock ----------------
  // a dropped programming voltage ends the frame even with no clock
  assign lnk_rst_n = i_nrst & i_lnk_vpp;

  // word changes only by programming, so per-bit sync is safe enough
  always_ff @(posedge i_lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      id_s1_q <= dir_pkg::ID_RESET;
      id_s2_q <= dir_pkg::ID_RESET;
    end else begin
      id_s1_q <= id_word;
      id_s2_q <= id_s1_q;
    end
  end

  assign cmd_full = {cmd_q, i_lnk_dat_i};

  always_ff @(posedge i_lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      state_q <= dir_pkg::DIR_LNK_CMD;
      cnt_q   <= '0;
      cmd_q   <= '0;
      sh_q    <= '0;
    end else begin
      case (state_q)
        dir_pkg::DIR_LNK_CMD: begin
          cmd_q <= cmd_full[2:0];
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == dir_pkg::CMD_LAST) begin
            cnt_q <= '0;
            if (cmd_full == dir_pkg::CMD_RD0 ||
                cmd_full == dir_pkg::CMD_RD1) begin
              sh_q    <= id_byte(id_s2_q, cmd_full[0]);
              state_q <= dir_pkg::DIR_LNK_RD;
            end else if (cmd_full == dir_pkg::CMD_PG0 ||
                         cmd_full == dir_pkg::CMD_PG1) begin
              state_q <= dir_pkg::DIR_LNK_WR;
            end
          end
        end
        dir_pkg::DIR_LNK_RD: begin
          sh_q  <= {sh_q[6:0], 1'b0};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == dir_pkg::DATA_LAST) begin
            state_q <= dir_pkg::DIR_LNK_CMD;
            cnt_q   <= '0;
          end
        end
        dir_pkg::DIR_LNK_WR: begin
          sh_q  <= {sh_q[6:0], i_lnk_dat_i};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == dir_pkg::DATA_LAST) begin
            state_q <= dir_pkg::DIR_LNK_CMD;
            cnt_q   <= '0;
          end
        end
        default: begin
          state_q <= dir_pkg::DIR_LNK_CMD;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // program capture survives the frame end so the other side can finish
  always_ff @(posedge i_lnk_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_data_q <= '1;
      wr_sel_q  <= 1'b0;
      wr_tgl_q  <= 1'b0;
    end else if (i_lnk_vpp && state_q == dir_pkg::DIR_LNK_WR &&
                 cnt_q == dir_pkg::DATA_LAST) begin
      wr_data_q <= {sh_q[6:0], i_lnk_dat_i};
      wr_sel_q  <= cmd_q[0];
      wr_tgl_q  <= ~wr_tgl_q;
    end
  end

  assign o_lnk_dat_oe = (state_q == dir_pkg::DIR_LNK_RD);
  assign o_lnk_dat_o  = sh_q[7];

  // ---------------- checks ----------------
  tbl_read_hit_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_tbl_req.rd && !prog_stb &&
     i_tbl_req.addr == dir_pkg::ID1_ADDR) |=>
      o_tbl_valid && o_tbl_hit &&
      o_tbl_data == id_word.part_code_high_bits)
    else $error("table read of second byte wrong");

  tbl_fields_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_tbl_req.rd && !prog_stb &&
     i_tbl_req.addr == dir_pkg::ID0_ADDR) |=>
      o_tbl_data[7:5] == id_word.part_code_low_bits &&
      o_tbl_data[4:0] == id_word.silicon_revision_field)
    else $error("first byte field layout wrong");

  tbl_unmapped_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_tbl_req.rd && i_tbl_req.addr[21:1] != 21'h1fffff) |=>
      o_tbl_valid && !o_tbl_hit && o_tbl_data == 8'h00)
    else $error("unmapped table read answered as hit");

  tbl_valid_pulse_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_tbl_req.rd) |=> !o_tbl_valid)
    else $error("valid without a table read");

  fw_write_keep_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (i_tbl_req.wr && !prog_stb) |=> $stable(id_word))
    else $error("firmware write altered identification");

  lnk_drive_len_a: assert property (
    @(posedge i_lnk_clk) disable iff (!lnk_rst_n)
    $rose(o_lnk_dat_oe) |-> o_lnk_dat_oe[*8] ##1 !o_lnk_dat_oe)
    else $error("link data not driven for eight clocks");

  lnk_first_bit_a: assert property (
    @(posedge i_lnk_clk) disable iff (!lnk_rst_n)
    (state_q == dir_pkg::DIR_LNK_CMD && cnt_q == dir_pkg::CMD_LAST &&
     cmd_full == dir_pkg::CMD_RD1) |=>
      o_lnk_dat_o == $past(id_s2_q[15]))
    else $error("link read first bit wrong");

  lnk_prog_tgl_a: assert property (
    @(posedge i_lnk_clk) disable iff (!lnk_rst_n)
    (state_q == dir_pkg::DIR_LNK_WR && cnt_q == dir_pkg::DATA_LAST) |=>
      wr_tgl_q != $past(wr_tgl_q))
    else $error("program request not raised");
endmodule // dir_top

// [sim/device_identification_readout_test.sv]
// Purpose: table-read and link tests for the identification block
// Assumes: inputs change at falling i_clk; link frames from the model
// Notes:   pattern a3/4c touches every field; later f0 shows ones keep
`timescale 1ns/1ps
module device_identification_readout_test;
  logic                  i_clk;
  logic                  i_nrst;
  logic                  i_ce;
  dir_pkg::dir_tbl_req_t req;
  logic [7:0]            tbl_data;
  logic                  tbl_valid;
  logic                  tbl_hit;
  logic                  lnk_clk;
  logic                  vpp;
  logic                  line;
  logic                  dev_dat;
  logic                  dev_oe;
  logic [7:0]            rb;
  int                    err_count;
  int                    samples_checked;
  int                    cyc;
  localparam logic [7:0] EXP0 = (8'(3'h5) << dir_pkg::PLO_LSB) |
                                (8'(5'h03) << dir_pkg::REV_LSB);

  dir_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_tbl_req(req), .o_tbl_data(tbl_data), .o_tbl_valid(tbl_valid),
    .o_tbl_hit(tbl_hit), .i_lnk_clk(lnk_clk), .i_lnk_vpp(vpp),
    .i_lnk_dat_i(line), .o_lnk_dat_o(dev_dat), .o_lnk_dat_oe(dev_oe));

  dir_prog_model pm (.o_lnk_clk(lnk_clk), .o_vpp(vpp), .o_line(line),
    .i_dev_dat(dev_dat), .i_dev_oe(dev_oe));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // a hang counts as a mismatch and ends in the same report
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // rd is left high so back-to-back calls assign it only once per edge
  task automatic tbl_rd(input logic [21:0] a, input logic [7:0] ed,
                        input logic eh);
    req.rd   = 1'b1;
    req.wr   = 1'b0;
    req.addr = a;
    @(negedge i_clk);
    chk("tbl valid", {7'h0, tbl_valid}, 8'h01);
    chk("tbl data", tbl_data, ed);
    chk("tbl hit", {7'h0, tbl_hit}, {7'h0, eh});
  endtask

  task automatic idle();
    req = '0;
    @(negedge i_clk);
    chk("tbl valid low", {7'h0, tbl_valid}, 8'h00);
  endtask

  // program frames must read back their own bits: device stays off line
  task automatic lnk(input logic [3:0] c, input logic [7:0] wd, exp);
    pm.frame(c, wd, rb);
    chk("link byte", rb, exp);
  endtask

  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    req = '0;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (10) @(negedge i_clk);
    chk("reset data", tbl_data, 8'h00);
    chk("reset oe", {7'h0, dev_oe}, 8'h00);
    i_nrst = 1'b1;
    tbl_rd(dir_pkg::ID0_ADDR, 8'hff, 1'b1);
    tbl_rd(dir_pkg::ID1_ADDR, 8'hff, 1'b1);
    tbl_rd(22'h3ffffd, 8'h00, 1'b0);
    tbl_rd(22'h200000, 8'h00, 1'b0);
    idle();
    $display("test unprogrammed table read done");
    #400;
    lnk(dir_pkg::CMD_RD0, 8'h00, 8'hff);
    lnk(dir_pkg::CMD_RD1, 8'h00, 8'hff);
    lnk(dir_pkg::CMD_PG0, EXP0, EXP0);
    lnk(dir_pkg::CMD_PG1, 8'h4c, 8'h4c);
    $display("test link read and program done");
    @(negedge i_clk);
    repeat (10) @(negedge i_clk);
    req = '{rd: 1'b0, wr: 1'b1, addr: dir_pkg::ID0_ADDR, wdata: 8'h00};
    @(negedge i_clk);
    req.addr = dir_pkg::ID1_ADDR;
    @(negedge i_clk);
    tbl_rd(dir_pkg::ID0_ADDR, EXP0, 1'b1);
    tbl_rd(dir_pkg::ID1_ADDR, 8'h4c, 1'b1);
    i_ce = 1'b0;
    @(negedge i_clk);
    // a frozen clock holds the last answer, valid included
    chk("frozen valid", {7'h0, tbl_valid}, 8'h01);
    chk("frozen data", tbl_data, 8'h4c);
    i_ce = 1'b1;
    idle();
    $display("test write attempt and field read done");
    pm.cut_frame(dir_pkg::CMD_PG0);
    lnk(dir_pkg::CMD_RD0, 8'h00, EXP0);
    lnk(dir_pkg::CMD_RD1, 8'h00, 8'h4c);
    lnk(dir_pkg::CMD_PG1, 8'hf0, 8'hf0);
    // command without its valid bit: the zeros that follow must not burn
    lnk(4'h4, 8'h00, 8'h00);
    lnk(dir_pkg::CMD_RD1, 8'h00, 8'h40);
    @(negedge i_clk);
    repeat (10) @(negedge i_clk);
    tbl_rd(dir_pkg::ID1_ADDR, 8'h40, 1'b1);
    idle();
    $display("test one-way programming done");
    complete_run();
  end
endmodule // device_identification_readout_test

// [sim/dir_prog_model.sv]
// Purpose: programmer model that drives the serial identification link
// Assumes: device samples data on the rising link clock, MSB first
// Notes:   link clock stands low between frames; released line toggles
`timescale 1ns/1ps
module dir_prog_model (
  output logic      o_lnk_clk,
  output logic      o_vpp,
  output logic      o_line,
  input  wire logic i_dev_dat,
  input  wire logic i_dev_oe
);
  logic drv;

  // released line shows the inverse of its last level, never a stale copy
  assign o_line = i_dev_oe ? i_dev_dat : drv;

  initial begin
    o_lnk_clk = 1'b0;
    o_vpp     = 1'b0;
    drv       = 1'b0;
    #300 o_vpp = 1'b1;
  end

  task automatic frame(input logic [3:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [11:0] bits;
    bits = {cmd, wd};
    #7;
    for (int i = 11; i >= 0; i--) begin
      drv = (i > 7 || cmd[2]) ? bits[i] : ~drv;
      #40;
      if (i < 8) rd[i] = o_line;
      #40 o_lnk_clk = 1'b1;
      #80 o_lnk_clk = 1'b0;
    end
    drv = ~drv;
  endtask

  // program frame cut by dropping the voltage; nothing may be burned
  task automatic cut_frame(input logic [3:0] cmd);
    #7;
    for (int i = 3; i >= 0; i--) begin
      drv = cmd[i];
      #80 o_lnk_clk = 1'b1;
      #80 o_lnk_clk = 1'b0;
    end
    drv = 1'b0;
    repeat (3) begin
      #80 o_lnk_clk = 1'b1;
      #80 o_lnk_clk = 1'b0;
    end
    o_vpp = 1'b0;
    #400 o_vpp = 1'b1;
    #400;
  endtask
endmodule // dir_prog_model
